// file: logic/dbl_pkg.sv
// shared constants and types of the divide and bitwise logic unit
package dbl_pkg;

  localparam int DATA_W  = 16;
  localparam int TEMP_W  = 32;
  localparam int SCALE_W = 5;
  localparam int CNT_W   = 6;

  // execution times in clock cycles, from request edge to done pulse
  localparam logic [CNT_W-1:0] LAT_DIV_SIGNED   = 6'h27;
  localparam logic [CNT_W-1:0] LAT_DIV_UNSIGNED = 6'h26;
  localparam logic [CNT_W-1:0] LAT_NOT          = 6'h05;
  localparam logic [CNT_W-1:0] LAT_NEG          = 6'h05;
  localparam logic [CNT_W-1:0] LAT_LOGIC        = 6'h0A;

  // restoring divider steps, one quotient bit per cycle
  localparam logic [CNT_W-1:0] DIV_STEPS = 6'h20;

  // saturation values and limits
  localparam logic [DATA_W-1:0] SAT_UNSIGNED_MAX = 16'hFFFF;
  localparam logic [DATA_W-1:0] SAT_SIGNED_MAX   = 16'h7FFF;
  localparam logic [DATA_W-1:0] SAT_SIGNED_MIN   = 16'h8000;
  localparam logic [DATA_W-1:0] ZERO_WORD        = 16'h0000;
  localparam logic [TEMP_W-1:0] LIM_UNSIGNED     = 32'h0000_FFFF;
  localparam logic [TEMP_W-1:0] LIM_SIGNED_POS   = 32'h0000_7FFF;
  localparam logic [TEMP_W-1:0] LIM_SIGNED_NEG   = 32'h0000_8000;

  typedef enum logic [2:0] {
    OP_NOT = 3'h0,
    OP_NEG = 3'h1,
    OP_AND = 3'h2,
    OP_OR  = 3'h3,
    OP_XOR = 3'h4,
    OP_DIV = 3'h5
  } dbl_op_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'h0,
    ST_RUN  = 1'h1
  } dbl_state_t;

endpackage : dbl_pkg

// file: logic/dbl_divider.sv
// unsigned restoring divider, one quotient bit per clock
`timescale 1ns/1ps
module dbl_divider
  import dbl_pkg::*;
#(
  parameter int NUM_W = 32,
  parameter int DEN_W = 16
) (
  input  wire logic             clock,     // unit clock
  input  wire logic             rst,       // synchronous reset, active high
  input  wire logic             start,     // one-cycle load pulse
  input  wire logic [NUM_W-1:0] numerator, // dividend magnitude
  input  wire logic [DEN_W-1:0] denominator, // divisor magnitude
  output logic      [NUM_W-1:0] quotient,  // quotient magnitude
  output logic                  running    // high while stepping
);

  typedef struct packed {
    dbl_state_t       state;
    logic [CNT_W-1:0] cnt;
    logic [DEN_W-1:0] rem;
    logic [NUM_W-1:0] quo;
    logic [DEN_W-1:0] dvs;
  } dbl_div_state_t;

  localparam dbl_div_state_t DIV_RESET = '{ST_IDLE, '0, '0, '0, '0};

  dbl_div_state_t q;
  dbl_div_state_t d;
  logic [DEN_W:0] trial;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    d     = q;
    trial = {q.rem, q.quo[NUM_W-1]};
    case (q.state)
      ST_IDLE: begin
        if (start) begin
          d.state = ST_RUN;
          d.cnt   = DIV_STEPS;
          d.rem   = '0;
          d.quo   = numerator;
          d.dvs   = denominator;
        end
      end
      ST_RUN: begin
        if (trial >= {1'b0, q.dvs}) begin
          d.rem = DEN_W'(trial - {1'b0, q.dvs});
          d.quo = {q.quo[NUM_W-2:0], 1'b1};
        end else begin
          d.rem = trial[DEN_W-1:0];
          d.quo = {q.quo[NUM_W-2:0], 1'b0};
        end
        d.cnt = q.cnt - 6'h01;
        if (q.cnt == 6'h01) begin
          d.state = ST_IDLE;
        end
      end
      default: d = DIV_RESET;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= DIV_RESET;
    end else begin
      q <= d;
    end
  end

  assign quotient = q.quo;
  assign running  = (q.state == ST_RUN);

endmodule : dbl_divider

// file: logic/dbl_unit.sv
// divide and bitwise logic unit: saturating divider, not, negate, and, or, xor
// Overview of operation
// - a signed quotient beyond the 32-bit signed range keeps its low bits, overflow clear.
// - inversion returns the bitwise complement of the first operand.
// - negation returns the two's complement of the first operand.
// - the and function sets a result bit only where both operand bits are one.
// - the or function sets a result bit where either operand bit is one.
// - the exclusive-or function sets a result bit where the operand bits differ.
`timescale 1ns/1ps
module dbl_unit
  import dbl_pkg::*;
(
  input  wire logic               clock,         // 10 MHz unit clock
  input  wire logic               rst,           // synchronous reset, active high
  input  wire logic               start,         // request pulse, taken when idle
  input  wire logic [2:0]         opcode,        // function select, dbl_op_t coding
  input  wire logic [DATA_W-1:0]  firstOperand,  // operand of not, negate and logic ops
  input  wire logic [DATA_W-1:0]  secondOperand, // second operand of logic ops
  input  wire logic [DATA_W-1:0]  dividendIn,    // divider dividend
  input  wire logic [DATA_W-1:0]  divisorIn,     // divider divisor
  input  wire logic [SCALE_W-1:0] scale,         // dividend scale exponent
  input  wire logic               signedMode,    // divider mode, 1 signed
  output logic      [DATA_W-1:0]  result,        // result word
  output logic                    overflowFlag,  // divider overflow
  output logic                    done,          // one-cycle completion pulse
  output logic                    busy           // high while executing
);

  typedef struct packed {
    dbl_state_t       state;
    dbl_op_t          op;
    logic [CNT_W-1:0] cnt;
    logic [DATA_W-1:0] opA;
    logic [DATA_W-1:0] opB;
    logic             sgn;
    logic             resNeg;
    logic             zeroDiv;
    logic [DATA_W-1:0] result;
    logic             ovf;
    logic             wrapped;
    logic             done;
    logic             busy;
  } dbl_unit_state_t;

  localparam dbl_unit_state_t UNIT_RESET =
    '{ST_IDLE, OP_NOT, '0, '0, '0, 1'b0, 1'b0, 1'b0, '0, 1'b0, 1'b0, 1'b0, 1'b0};

  dbl_unit_state_t   q;
  dbl_unit_state_t   d;
  dbl_op_t           reqOp;
  logic              opValid;
  logic [TEMP_W-1:0] temp;
  logic              tNeg;
  logic [TEMP_W-1:0] tMag;
  logic              dNeg;
  logic [DATA_W-1:0] dMag;
  logic              divStart;
  logic [TEMP_W-1:0] quot;
  logic              divRunning;

  function automatic logic [CNT_W-1:0] latencyOf(input dbl_op_t op, input logic sgn);
    case (op)
      OP_NOT:  latencyOf = LAT_NOT;
      OP_NEG:  latencyOf = LAT_NEG;
      OP_DIV:  latencyOf = sgn ? LAT_DIV_SIGNED : LAT_DIV_UNSIGNED;
      default: latencyOf = LAT_LOGIC;
    endcase
  endfunction : latencyOf

  ////////////////////////////////////////////////////////////////////////
  // scaled dividend and operand magnitudes
  always_comb begin
    reqOp   = dbl_op_t'(opcode);
    opValid = (opcode <= 3'h5);
    if (signedMode) begin
      temp = {{(TEMP_W-DATA_W){dividendIn[DATA_W-1]}}, dividendIn} << scale;
    end else begin
      temp = {{(TEMP_W-DATA_W){1'b0}}, dividendIn} << scale;
    end
    tNeg = signedMode & temp[TEMP_W-1];
    tMag = tNeg ? (~temp + 32'h0000_0001) : temp;
    dNeg = signedMode & divisorIn[DATA_W-1];
    dMag = dNeg ? (~divisorIn + 16'h0001) : divisorIn;
  end

  dbl_divider #(
    .NUM_W (TEMP_W),
    .DEN_W (DATA_W)
  ) u_divider (
    .clock       (clock),
    .rst         (rst),
    .start       (divStart),
    .numerator   (tMag),
    .denominator (dMag),
    .quotient    (quot),
    .running     (divRunning)
  );

  ////////////////////////////////////////////////////////////////////////
  // sequencing and result selection
  always_comb begin
    d        = q;
    d.done   = 1'b0;
    divStart = 1'b0;
    case (q.state)
      ST_IDLE: begin
        if (start && opValid) begin
          d.state   = ST_RUN;
          d.busy    = 1'b1;
          d.op      = reqOp;
          d.opA     = firstOperand;
          d.opB     = secondOperand;
          d.sgn     = signedMode;
          d.resNeg  = tNeg ^ dNeg;
          d.zeroDiv = (divisorIn == ZERO_WORD);
          d.cnt     = latencyOf(reqOp, signedMode) - 6'h01;
          divStart  = (reqOp == OP_DIV);
        end
      end
      ST_RUN: begin
        if (q.cnt == 6'h00) begin
          d.state   = ST_IDLE;
          d.busy    = 1'b0;
          d.done    = 1'b1;
          d.ovf     = 1'b0;
          d.wrapped = 1'b0;
          case (q.op)
            OP_NOT: d.result = ~q.opA;
            OP_NEG: d.result = ~q.opA + 16'h0001;
            OP_AND: d.result = q.opA & q.opB;
            OP_OR:  d.result = q.opA | q.opB;
            OP_XOR: d.result = q.opA ^ q.opB;
            default: begin
              if (q.zeroDiv) begin
                d.result = ZERO_WORD;
                d.ovf    = 1'b1;
              end else if (!q.sgn) begin
                if (quot > LIM_UNSIGNED) begin
                  d.result = SAT_UNSIGNED_MAX;
                  d.ovf    = 1'b1;
                end else begin
                  d.result = quot[DATA_W-1:0];
                end
              end else if (!q.resNeg) begin
                if (quot[TEMP_W-1]) begin
                  d.result  = quot[DATA_W-1:0];
                  d.wrapped = 1'b1;
                end else if (quot > LIM_SIGNED_POS) begin
                  d.result = SAT_SIGNED_MAX;
                  d.ovf    = 1'b1;
                end else begin
                  d.result = quot[DATA_W-1:0];
                end
              end else if (quot > LIM_SIGNED_NEG) begin
                d.result = SAT_SIGNED_MIN;
                d.ovf    = 1'b1;
              end else begin
                d.result = ~quot[DATA_W-1:0] + 16'h0001;
              end
            end
          endcase
        end else begin
          d.cnt = q.cnt - 6'h01;
        end
      end
      default: d = UNIT_RESET;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= UNIT_RESET;
    end else begin
      q <= d;
    end
  end

  assign result       = q.result;
  assign overflowFlag = q.ovf;
  assign done         = q.done;
  assign busy         = q.busy;

  ////////////////////////////////////////////////////////////////////////
  // checks
  logic takeReq;
  assign takeReq = start && !q.busy;

  a_not_value: assert property (@(posedge clock) disable iff (rst)
    takeReq && opcode == 3'h0 |-> ##6 (done && result == ~$past(firstOperand, 6)))
    else $error("inversion result wrong or late");

  a_neg_value: assert property (@(posedge clock) disable iff (rst)
    takeReq && opcode == 3'h1 |-> ##6 (done && (result + $past(firstOperand, 6)) == 16'h0000))
    else $error("negation result wrong or late");

  a_and_value: assert property (@(posedge clock) disable iff (rst)
    takeReq && opcode == 3'h2 |->
      ##11 (done && result == ($past(firstOperand, 11) & $past(secondOperand, 11))))
    else $error("and result wrong or late");

  a_or_value: assert property (@(posedge clock) disable iff (rst)
    takeReq && opcode == 3'h3 |->
      ##11 (done && result == ($past(firstOperand, 11) | $past(secondOperand, 11))))
    else $error("or result wrong or late");

  a_xor_value: assert property (@(posedge clock) disable iff (rst)
    takeReq && opcode == 3'h4 |->
      ##11 (done && result == ($past(firstOperand, 11) ^ $past(secondOperand, 11))))
    else $error("xor result wrong or late");

  a_div_zero: assert property (@(posedge clock) disable iff (rst)
    takeReq && opcode == 3'h5 && divisorIn == 16'h0000 |->
      ##[39:40] (done && result == 16'h0000 && overflowFlag))
    else $error("zero divisor not flagged");

  a_div_saturate: assert property (@(posedge clock) disable iff (rst)
    done && overflowFlag && !q.sgn && !q.zeroDiv |-> result == 16'hFFFF)
    else $error("unsigned overflow not saturated");

  a_div_settled: assert property (@(posedge clock) disable iff (rst)
    q.state == ST_RUN && q.cnt == 6'h00 && q.op == OP_DIV |-> !divRunning)
    else $error("quotient read before divider finished");

  a_div_signsat: assert property (@(posedge clock) disable iff (rst)
    done && overflowFlag && q.sgn && !q.zeroDiv |->
      result == (q.resNeg ? 16'h8000 : 16'h7FFF))
    else $error("signed overflow not saturated");

  a_div_wrap: assert property (@(posedge clock) disable iff (rst)
    done && q.wrapped |-> !overflowFlag && q.sgn && !q.resNeg)
    else $error("wrapped quotient raised overflow");

endmodule : dbl_unit

// file: verif/dbl_requester.sv
// requester model: control design issuing one unit operation at a time
`timescale 1ns/1ps
module dbl_requester
  import dbl_pkg::*;
(
  input  wire logic               clock,         // unit clock
  input  wire logic               busy,          // unit executing
  output logic                    start,         // request pulse
  output logic      [2:0]         opcode,        // function select
  output logic      [DATA_W-1:0]  firstOperand,  // first operand
  output logic      [DATA_W-1:0]  secondOperand, // second operand
  output logic      [DATA_W-1:0]  dividendIn,    // dividend
  output logic      [DATA_W-1:0]  divisorIn,     // divisor
  output logic      [SCALE_W-1:0] scale,         // dividend scale
  output logic                    signedMode     // divide mode
);
  initial begin
    start = 1'b0;
    {opcode, firstOperand, secondOperand, dividendIn, divisorIn, scale, signedMode} = '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // waits for idle, holds the request over the taking edge, then scrambles the lines
  task automatic send(input logic [2:0] op, input logic [DATA_W-1:0] a, b, dd, dv,
                      input logic [SCALE_W-1:0] sc, input logic sm);
    @(negedge clock);
    while (busy) @(negedge clock);
    if (op == OP_NEG && a == SAT_SIGNED_MIN) a = SAT_SIGNED_MAX;
    start = 1'b1;
    {opcode, firstOperand, secondOperand, dividendIn, divisorIn, scale, signedMode} =
      {op, a, b, dd, dv, sc, sm};
    @(negedge clock);
    start = 1'b0;
    {firstOperand, secondOperand, dividendIn, divisorIn, scale, signedMode} =
      ~{firstOperand, secondOperand, dividendIn, divisorIn, scale, signedMode};
  endtask : send

  // one-cycle start with no wait for idle
  task automatic poke(input logic [2:0] op);
    @(negedge clock);
    start = 1'b1;
    opcode = op;
    @(negedge clock);
    start = 1'b0;
  endtask : poke
endmodule : dbl_requester

// file: verif/test_dbl_unit.sv
// self-checking bench of the divide and bitwise logic unit
`timescale 1ns/1ps
module test_dbl_unit
  import dbl_pkg::*;
;
  typedef struct {logic [15:0] res; logic ov; int due;} dbl_note_t;
  logic               clock = 1'b0;
  logic               rst   = 1'b1;
  logic               start, signedMode, overflowFlag, done, busy;
  logic [2:0]         opcode;
  logic [DATA_W-1:0]  firstOperand, secondOperand, dividendIn, divisorIn, result;
  logic [SCALE_W-1:0] scale;
  int                 cyc = 0;
  int                 fails = 0;
  int                 n_compared = 0;
  int                 seed = 34334;
  dbl_note_t          notes[$];
  dbl_note_t          note;
  logic [15:0]        ra;
  logic [2:0]         rop;
  // dividend, divisor, scale, mode
  localparam logic [37:0] DIVS [9] = '{
    {16'h1234, 16'h0000, 5'h03, 1'b0}, {16'h8000, 16'h0000, 5'h00, 1'b1},
    {16'hFFFF, 16'h0001, 5'h10, 1'b0}, {16'h0064, 16'h0007, 5'h04, 1'b0},
    {16'h7FFF, 16'h0001, 5'h01, 1'b1}, {16'h8000, 16'h0001, 5'h01, 1'b1},
    {16'hFF9C, 16'h0007, 5'h02, 1'b1}, {16'h8000, 16'hFFFF, 5'h10, 1'b1},
    {16'h0001, 16'hFFFF, 5'h0F, 1'b1}};

  always #50 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;

  dbl_unit u_dut (.clock(clock), .rst(rst), .start(start), .opcode(opcode),
    .firstOperand(firstOperand), .secondOperand(secondOperand), .dividendIn(dividendIn),
    .divisorIn(divisorIn), .scale(scale), .signedMode(signedMode), .result(result),
    .overflowFlag(overflowFlag), .done(done), .busy(busy));
  dbl_requester u_req (.clock(clock), .busy(busy), .start(start), .opcode(opcode),
    .firstOperand(firstOperand), .secondOperand(secondOperand), .dividendIn(dividendIn),
    .divisorIn(divisorIn), .scale(scale), .signedMode(signedMode));

  ////////////////////////////////////////////////////////////////////////////////
  // expected result with overflow in bit 16
  function automatic logic [16:0] model(input logic [2:0] op, input logic [15:0] a, b, dd,
                                        input logic [15:0] dv, input logic [4:0] sc,
                                        input logic sm);
    int     t;
    longint q;
    case (op)
      OP_NOT: return {1'b0, ~a};
      OP_NEG: return {1'b0, 16'(-a)};
      OP_AND: return {1'b0, a & b};
      OP_OR:  return {1'b0, a | b};
      OP_XOR: return {1'b0, a ^ b};
      default: ;
    endcase
    if (dv == 16'h0000) return {1'b1, 16'h0000};
    if (!sm) begin
      q = longint'({16'h0000, dd} << sc) / longint'(dv);
      return (q > 64'sh0000_FFFF) ? {1'b1, 16'hFFFF} : {1'b0, q[15:0]};
    end
    t = $signed(dd);
    t = t <<< sc;
    q = longint'(t) / longint'($signed(dv));
    // beyond the 32-bit signed range the low bits pass unflagged
    if (q > 64'sh7FFF_FFFF) return {1'b0, q[15:0]};
    if (q > 64'sh0000_7FFF) return {1'b1, 16'h7FFF};
    if (q < -64'sh0000_8000) return {1'b1, 16'h8000};
    return {1'b0, q[15:0]};
  endfunction : model

  function automatic int lat(input logic [2:0] op, input logic sm);
    if (op == OP_DIV) return sm ? int'(LAT_DIV_SIGNED) : int'(LAT_DIV_UNSIGNED);
    return (op <= OP_NEG) ? int'(LAT_NOT) : int'(LAT_LOGIC);
  endfunction : lat

  task automatic go(input logic [2:0] op, input logic [15:0] a, b, dd, dv,
                    input logic [4:0] sc, input logic sm);
    logic [16:0] e;
    u_req.send(op, a, b, dd, dv, sc, sm);
    e = model(op, a, b, dd, dv, sc, sm);
    notes.push_back(dbl_note_t'{e[15:0], e[16], cyc + lat(op, sm)});
  endtask : go

  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s: expected %b, seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////////
  // result watcher: each done pulse consumes the oldest note
  always @(negedge clock) begin
    if (!rst && done === 1'b1) begin
      if (notes.size() == 0) begin
        chk_bit("unexpected done", 1'b0, done);
      end else begin
        note = notes.pop_front();
        chk_word("result", note.res, result);
        chk_bit("overflowFlag", note.ov, overflowFlag);
        chk_word("done cycle", note.due[15:0], cyc[15:0]);
      end
    end
  end

  initial begin
    #3000000;
    fails++;
    report_and_stop();
  end

  initial begin
    repeat (5) @(negedge clock);
    rst = 1'b0;
    chk_word("result after reset", 16'h0000, result);
    chk_bit("busy after reset", 1'b0, busy);
    chk_bit("overflow after reset", 1'b0, overflowFlag);
    go(OP_NOT, 16'h782C, 16'h0000, 16'h0000, 16'h0001, 5'h00, 1'b0);
    go(OP_NOT, 16'h0000, 16'hFFFF, 16'h0000, 16'h0001, 5'h00, 1'b0);
    go(OP_NEG, 16'h7FFF, 16'h0000, 16'h0000, 16'h0001, 5'h00, 1'b0);
    go(OP_NEG, 16'h8001, 16'h0000, 16'h0000, 16'h0001, 5'h00, 1'b0);
    for (int op = 2; op <= 4; op++) begin
      go(3'(op), 16'h14C7, 16'h782C, 16'h0000, 16'h0001, 5'h00, 1'b0);
      go(3'(op), 16'hFFFF, 16'h5A5A, 16'h0000, 16'h0001, 5'h00, 1'b0);
    end
    foreach (DIVS[i]) begin
      go(OP_DIV, 16'h0000, 16'h0000, DIVS[i][37:22], DIVS[i][21:6], DIVS[i][5:1],
         DIVS[i][0]);
    end
    // requests while busy and unused codes must be ignored
    go(OP_DIV, 16'h0000, 16'h0000, 16'h0100, 16'h0003, 5'h02, 1'b0);
    u_req.poke(OP_AND);
    while (busy) @(negedge clock);
    u_req.poke(3'h6);
    u_req.poke(3'h7);
    repeat (60) begin
      rop = 3'($unsigned($random(seed)) % 6);
      ra = 16'($random(seed));
      if (rop == OP_NEG && ra == 16'h8000) ra = 16'h7FFF;
      go(rop, ra, 16'($random(seed)), 16'($random(seed)), 16'($random(seed)),
         5'($unsigned($random(seed)) % 17), 1'($random(seed)));
    end
    repeat (50) @(negedge clock);
    chk_word("pending notes", 16'h0000, 16'(notes.size()));
    report_and_stop();
  end
endmodule : test_dbl_unit
